// ==== plsc_strap.sv ====
// Shared constants and types of the LED and strap block, and the dual-purpose pin cell.
// Assumes one 25 MHz clock and a synchronous active-high reset shared by every file.

// ****************************************************************
// Package
// ****************************************************************
package plsc_pkg;
    localparam int STRAP_W = 5;
    localparam int HDATA_W = 32;

    // Register byte offsets.
    localparam logic [7:0] REG_CTRL_OFS = 8'h00;
    localparam logic [7:0] REG_STATUS_OFS = 8'h04;
    localparam logic [7:0] REG_ACTIVITY_OFS = 8'h08;

    // Control register fields.
    localparam int CTRL_ADDR_LSB = 0;
    localparam int CTRL_AUTONEG_BIT = 8;
    localparam int CTRL_FORCED_100_BIT = 9;
    localparam int CTRL_FORCED_FULL_BIT = 10;
    localparam int CTRL_ISOLATE_BIT = 12;

    // Status register fields.
    localparam int STAT_LINK_BIT = 0;
    localparam int STAT_SPEED_BIT = 1;
    localparam int STAT_FULL_BIT = 2;
    localparam int STAT_ISOLATE_BIT = 3;
    localparam int STAT_AN_DONE_BIT = 4;

    // Activity register fields.
    localparam int ACT_TX_BIT = 0;
    localparam int ACT_RX_BIT = 1;
    localparam int ACT_COL_BIT = 2;
    localparam int ACT_MATCH_BIT = 3;

    // Reset values of the control fields, and the strapped address that selects isolate.
    localparam logic RST_AUTONEG = 1'h1;
    localparam logic RST_FORCED_100 = 1'h1;
    localparam logic RST_FORCED_FULL = 1'h0;
    localparam logic [STRAP_W-1:0] ISOLATE_ADDR = 5'h00;

    // Indicator positions on the dual-purpose pins.
    localparam int PIN_DUPLEX = 0;
    localparam int PIN_COLLISION = 1;
    localparam int PIN_LINK = 2;
    localparam int PIN_TX = 3;
    localparam int PIN_RX = 4;

    // Register selected by the pending bus data phase.
    typedef enum logic [1:0] {
        SEL_CTRL,
        SEL_STATUS,
        SEL_ACTIVITY,
        SEL_NONE
    } plsc_sel_type;
endpackage

`timescale 1ns/100ps

// ****************************************************************
// Dual-purpose pin cell
// ****************************************************************
module plsc_strap_pins
    import plsc_pkg::*;
#(
    parameter int WIDTH = STRAP_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Indicator levels to show
    input wire logic [WIDTH-1:0] led_value,
    // Pin drive
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe_n
);
    typedef struct packed {
        logic [WIDTH-1:0] out;
        logic [WIDTH-1:0] oe_n;
    } plsc_pin_type;

    plsc_pin_type state_q;
    plsc_pin_type state_d;
    logic [WIDTH-1:0] out_d;
    logic [WIDTH-1:0] oe_n_d;

    // Pins float during reset so the straps can be read, then turn into indicator outputs.
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        assign out_d[i] = sys_rst ? 1'h0 : led_value[i];
        assign oe_n_d[i] = sys_rst;
    end

    always_comb begin
        state_d.out = out_d;
        state_d.oe_n = oe_n_d;
    end

    always_ff @(posedge core_clk) begin
        state_q <= state_d;
    end

    assign pin_out = state_q.out;
    assign pin_oe_n = state_q.oe_n;
endmodule // plsc_strap_pins

// ==== plsc_top.sv ====
// Status indicator and address strap control of a 10/100 transceiver, with an AHB-Lite register slave.
// Assumes core_clk is the 25 MHz reference and sys_rst is synchronous; the straps are stable during reset.
//
// Contract
// - Speed indicator is high at 100 Mb/s and low at 10 Mb/s.
// - Transmit indicator is on during transmit activity, off otherwise.
// - Receive indicator is on during receive activity, off otherwise.
// - Duplex indicator shows full-duplex operation of the link.
// - Collision indicator shows collisions, only in half-duplex mode.
// - Link indicator shows good link at either speed.
// - Five address straps are sampled at reset into the control register.
// - Every five-bit strapped address, zero included, is a valid address.
// - A strapped address of zero at reset selects isolate mode.
// - Software writing address zero later does not select isolate mode.
// - After reset the strap pins become indicator outputs.
// - Transmit driver signalling follows forced setting or negotiation result.
// - Receive path signalling follows forced setting or negotiation result.

`timescale 1ns/100ps

module plsc_top
    import plsc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [HDATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [HDATA_W-1:0] hrdata,
    // Link state from the transceiver core
    input wire logic link_up,
    input wire logic an_done,
    input wire logic an_speed_100,
    input wire logic an_full_duplex,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic collision_detect,
    // Management frame address check
    input wire logic mgmt_frame_valid,
    input wire logic [STRAP_W-1:0] mgmt_frame_addr,
    output logic mgmt_addr_match,
    // Dual-purpose strap and indicator pins
    input wire logic [STRAP_W-1:0] station_address_strap_in,
    output logic [STRAP_W-1:0] station_address_strap_out,
    output logic [STRAP_W-1:0] station_address_strap_oe_n,
    // Dedicated indicator and line configuration
    output logic speed_indicator,
    output logic line_tx_pair_100,
    output logic line_rx_pair_100,
    output logic mii_isolate
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [STRAP_W-1:0] station_addr;
        logic autoneg_en;
        logic forced_100;
        logic forced_full;
        logic isolate;
        logic ph_pend;
        logic ph_write;
        plsc_sel_type ph_sel;
        logic hreadyout;
        logic [HDATA_W-1:0] hrdata;
        logic speed_ind;
        logic tx_sig_100;
        logic rx_sig_100;
        logic addr_match;
    } plsc_regs_type;

    plsc_regs_type state_q;
    plsc_regs_type state_d;

    logic res_speed_100;
    logic res_full;
    logic bus_take;
    logic [STRAP_W-1:0] led_value;
    logic [HDATA_W-1:0] ctrl_word;
    logic [HDATA_W-1:0] status_word;
    logic [HDATA_W-1:0] activity_word;

    // ****************************************************************
    // Speed and duplex resolution
    // ****************************************************************
    // Negotiation results are trusted only once negotiation has finished.
    // Until then the forced setting stands, so the line never swings on a half-made decision.
    always_comb begin
        if (state_q.autoneg_en && an_done) begin
            res_speed_100 = an_speed_100;
            res_full = an_full_duplex;
        end else begin
            res_speed_100 = state_q.forced_100;
            res_full = state_q.forced_full;
        end
    end

    // ****************************************************************
    // Indicator levels
    // ****************************************************************
    always_comb begin
        led_value = '0;
        led_value[PIN_DUPLEX] = link_up && res_full;
        led_value[PIN_COLLISION] = collision_detect && !res_full;
        led_value[PIN_LINK] = link_up;
        led_value[PIN_TX] = tx_active;
        led_value[PIN_RX] = rx_active;
    end

    // ****************************************************************
    // Register read words
    // ****************************************************************
    always_comb begin
        ctrl_word = '0;
        ctrl_word[CTRL_ADDR_LSB +: STRAP_W] = state_q.station_addr;
        ctrl_word[CTRL_AUTONEG_BIT] = state_q.autoneg_en;
        ctrl_word[CTRL_FORCED_100_BIT] = state_q.forced_100;
        ctrl_word[CTRL_FORCED_FULL_BIT] = state_q.forced_full;
        ctrl_word[CTRL_ISOLATE_BIT] = state_q.isolate;
        status_word = '0;
        status_word[STAT_LINK_BIT] = link_up;
        status_word[STAT_SPEED_BIT] = res_speed_100;
        status_word[STAT_FULL_BIT] = res_full;
        status_word[STAT_ISOLATE_BIT] = state_q.isolate;
        status_word[STAT_AN_DONE_BIT] = an_done;
        activity_word = '0;
        activity_word[ACT_TX_BIT] = tx_active;
        activity_word[ACT_RX_BIT] = rx_active;
        activity_word[ACT_COL_BIT] = collision_detect;
        activity_word[ACT_MATCH_BIT] = state_q.addr_match;
    end

    assign bus_take = hsel && htrans[1] && hready;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        state_d = state_q;

        // Line signalling follows the resolved speed.
        state_d.speed_ind = res_speed_100;
        state_d.tx_sig_100 = res_speed_100;
        state_d.rx_sig_100 = res_speed_100;

        // No address is special here; zero answers like any other.
        state_d.addr_match = mgmt_frame_valid && (mgmt_frame_addr == state_q.station_addr);

        // Every transfer takes one wait state so read data can leave a flip-flop.
        if (state_q.ph_pend) begin
            state_d.ph_pend = 1'h0;
            state_d.hreadyout = 1'h1;
            if (state_q.ph_write) begin
                if (state_q.ph_sel == SEL_CTRL) begin
                    // Writing any address, zero included, sets isolate from the written isolate bit alone.
                    state_d.station_addr = hwdata[CTRL_ADDR_LSB +: STRAP_W];
                    state_d.autoneg_en = hwdata[CTRL_AUTONEG_BIT];
                    state_d.forced_100 = hwdata[CTRL_FORCED_100_BIT];
                    state_d.forced_full = hwdata[CTRL_FORCED_FULL_BIT];
                    state_d.isolate = hwdata[CTRL_ISOLATE_BIT];
                end
            end else begin
                unique case (state_q.ph_sel)
                    SEL_CTRL: begin
                        state_d.hrdata = ctrl_word;
                    end
                    SEL_STATUS: begin
                        state_d.hrdata = status_word;
                    end
                    SEL_ACTIVITY: begin
                        state_d.hrdata = activity_word;
                    end
                    SEL_NONE: begin
                        state_d.hrdata = '0;
                    end
                endcase
            end
        end else if (bus_take) begin
            state_d.ph_pend = 1'h1;
            state_d.hreadyout = 1'h0;
            state_d.ph_write = hwrite;
            if (haddr[31:8] != 24'h000000) begin
                state_d.ph_sel = SEL_NONE;
            end else if (haddr[7:0] == REG_CTRL_OFS) begin
                state_d.ph_sel = SEL_CTRL;
            end else if (haddr[7:0] == REG_STATUS_OFS) begin
                state_d.ph_sel = SEL_STATUS;
            end else if (haddr[7:0] == REG_ACTIVITY_OFS) begin
                state_d.ph_sel = SEL_ACTIVITY;
            end else begin
                state_d.ph_sel = SEL_NONE;
            end
        end

        // Reset catches the straps on every cycle it is held, so the last cycle wins.
        if (sys_rst) begin
            state_d = '0;
            state_d.station_addr = station_address_strap_in;
            state_d.isolate = (station_address_strap_in == ISOLATE_ADDR);
            state_d.autoneg_en = RST_AUTONEG;
            state_d.forced_100 = RST_FORCED_100;
            state_d.forced_full = RST_FORCED_FULL;
            state_d.ph_sel = SEL_NONE;
            state_d.hreadyout = 1'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        state_q <= state_d;
    end

    // ****************************************************************
    // Dual-purpose pins
    // ****************************************************************
    plsc_strap_pins #(
        .WIDTH(STRAP_W)
    ) u_pins (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .led_value(led_value),
        .pin_out(station_address_strap_out),
        .pin_oe_n(station_address_strap_oe_n)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // The response is always OKAY; a constant needs no flip-flop of its own.
    assign hresp = 1'h0;
    assign hreadyout = state_q.hreadyout;
    assign hrdata = state_q.hrdata;
    assign mgmt_addr_match = state_q.addr_match;
    assign speed_indicator = state_q.speed_ind;
    assign line_tx_pair_100 = state_q.tx_sig_100;
    assign line_rx_pair_100 = state_q.rx_sig_100;
    assign mii_isolate = state_q.isolate;
endmodule // plsc_top

// ==== plsc_board.sv ====
// Board model: strap resistors and indicator LEDs on the five dual-purpose pins.
// Assumes the testbench sets the strap pattern before it releases reset.

`timescale 1ns/100ps

// ****************************************************************
// Board model
// ****************************************************************
module plsc_board
    import plsc_pkg::*;
(
    // Strap pattern and pin drive
    input wire logic [STRAP_W-1:0] strap_value,
    input wire logic [STRAP_W-1:0] pin_out,
    input wire logic [STRAP_W-1:0] pin_oe_n,
    // Resolved pin level
    output logic [STRAP_W-1:0] pin_level
);
    // A released pin falls back to its resistor, never to the last driven level.
    always_comb begin
        for (int i = 0; i < STRAP_W; i++) begin
            pin_level[i] = pin_oe_n[i] ? strap_value[i] : pin_out[i];
        end
    end
endmodule // plsc_board

// ==== plsc_top_checker.sv ====
// Concurrent checks on the ports of the indicator and strap block.
// Assumes one clock domain and a synchronous active-high reset.

`timescale 1ns/100ps

// ****************************************************************
// Checker
// ****************************************************************
module plsc_top_checker
    import plsc_pkg::*;
(
    // Clock, reset and bus
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    // Link state and management
    input wire logic link_up,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic collision_detect,
    input wire logic mgmt_frame_valid,
    input wire logic mgmt_addr_match,
    // Pins and line configuration
    input wire logic [STRAP_W-1:0] station_address_strap_in,
    input wire logic [STRAP_W-1:0] station_address_strap_out,
    input wire logic [STRAP_W-1:0] station_address_strap_oe_n,
    input wire logic speed_indicator,
    input wire logic line_tx_pair_100,
    input wire logic line_rx_pair_100,
    input wire logic mii_isolate
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    tx_led_a: assert property (!$past(sys_rst) |-> station_address_strap_out[PIN_TX] == $past(tx_active))
        else $error("tx indicator does not follow activity");
    rx_led_a: assert property (!$past(sys_rst) |-> station_address_strap_out[PIN_RX] == $past(rx_active))
        else $error("rx indicator does not follow activity");
    link_led_a: assert property (!$past(sys_rst) |-> station_address_strap_out[PIN_LINK] == $past(link_up))
        else $error("link indicator does not follow link");
    duplex_led_a: assert property (station_address_strap_out[PIN_DUPLEX] |-> $past(link_up))
        else $error("duplex indicator on without link");
    collision_led_a: assert property (station_address_strap_out[PIN_COLLISION] |->
        $past(collision_detect) && !station_address_strap_out[PIN_DUPLEX])
        else $error("collision indicator on without half-duplex collision");
    line_pairs_a: assert property (speed_indicator == line_tx_pair_100 && speed_indicator == line_rx_pair_100)
        else $error("line signalling differs from speed");
    pin_drive_a: assert property (station_address_strap_oe_n == {STRAP_W{$past(sys_rst)}})
        else $error("pin drive wrong around reset");
    strap_isolate_a: assert property ($fell(sys_rst) |-> mii_isolate == ($past(station_address_strap_in) == ISOLATE_ADDR))
        else $error("isolate does not match strapped address");
    match_pulse_a: assert property (mgmt_addr_match |-> $past(mgmt_frame_valid))
        else $error("address match without a frame");
    bus_wait_a: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
        else $error("bus wait state is not one cycle");
    cover property (mgmt_addr_match);
    cover property ($fell(sys_rst) ##1 mii_isolate);
    cover property (station_address_strap_out[PIN_COLLISION]);
endmodule // plsc_top_checker

bind plsc_top plsc_top_checker i_plsc_top_checker (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel),
    .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .link_up(link_up), .tx_active(tx_active),
    .rx_active(rx_active), .collision_detect(collision_detect), .mgmt_frame_valid(mgmt_frame_valid),
    .mgmt_addr_match(mgmt_addr_match), .station_address_strap_in(station_address_strap_in),
    .station_address_strap_out(station_address_strap_out), .station_address_strap_oe_n(station_address_strap_oe_n),
    .speed_indicator(speed_indicator), .line_tx_pair_100(line_tx_pair_100), .line_rx_pair_100(line_rx_pair_100),
    .mii_isolate(mii_isolate));

// ==== plsc_top_tb_top.sv ====
// Self-checking testbench of the indicator and strap block with its register slave.
// Assumes the board model resolves the pins and the checker is bound to the top module.

`timescale 1ns/100ps

// ****************************************************************
// Testbench
// ****************************************************************
module plsc_top_tb_top
    import plsc_pkg::*;
;
    typedef struct packed {logic [6:0] ins; logic [4:0] leds; logic spd;} plsc_row_type;
    // Row inputs: link, an_done, an_speed_100, an_full_duplex, tx, rx, collision.
    plsc_row_type rows [5] = '{'{7'h78, 5'h05, 1'h1}, '{7'h65, 5'h0E, 1'h0}, '{7'h6B, 5'h15, 1'h0},
        '{7'h06, 5'h18, 1'h1}, '{7'h39, 5'h00, 1'h1}};
    logic [4:0] straps [4] = '{5'h00, 5'h01, 5'h15, 5'h1F};
    logic [31:0] ctrl_words [4] = '{32'h00000200, 32'h00000000, 32'h00000300, 32'h00001600};
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic mgmt_frame_valid = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [6:0] lk = 7'h00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic [4:0] mgmt_frame_addr = 5'h00;
    logic [4:0] strap_value = 5'h00;
    logic [4:0] pin_level, pin_out, pin_oe_n;
    logic hreadyout, hresp, mgmt_addr_match, speed_indicator, line_tx, line_rx, mii_isolate;
    int fails = 0;
    int comparisons = 0;

    always #20 core_clk = ~core_clk;

    plsc_top i_plsc_top (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .link_up(lk[6]), .an_done(lk[5]), .an_speed_100(lk[4]), .an_full_duplex(lk[3]),
        .tx_active(lk[2]), .rx_active(lk[1]), .collision_detect(lk[0]), .mgmt_frame_valid(mgmt_frame_valid),
        .mgmt_frame_addr(mgmt_frame_addr), .mgmt_addr_match(mgmt_addr_match), .station_address_strap_in(pin_level),
        .station_address_strap_out(pin_out), .station_address_strap_oe_n(pin_oe_n),
        .speed_indicator(speed_indicator), .line_tx_pair_100(line_tx), .line_rx_pair_100(line_rx),
        .mii_isolate(mii_isolate));
    plsc_board i_plsc_board (.strap_value(strap_value), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_level(pin_level));

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_word(what, {31'h0, exp}, {31'h0, got});
    endtask
    // Ready is looked at in the low half of the cycle, where it is settled before the edge.
    task automatic wait_ready();
        logic ok;
        do begin
            @(negedge core_clk);
            ok = hreadyout;
            @(posedge core_clk);
        end while (ok !== 1'b1);
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        chk_bit("okay response", 1'b0, hresp);
    endtask
    task automatic do_reset(input logic [4:0] s);
        strap_value <= s;
        sys_rst <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk_word("oe_n in reset", 32'h1F, {27'h0, pin_oe_n});
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic frame(input logic [4:0] a, input logic exp);
        mgmt_frame_valid <= 1'b1;
        mgmt_frame_addr <= a;
        @(posedge core_clk);
        mgmt_frame_valid <= 1'b0;
        @(negedge core_clk);
        chk_bit("address match", exp, mgmt_addr_match);
        @(posedge core_clk);
    endtask
    task automatic complete_run();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        do_reset(5'h1F);
        chk_word("oe_n after reset", 32'h0, {27'h0, pin_oe_n});
        foreach (rows[i]) begin
            lk <= rows[i].ins;
            repeat (3) @(posedge core_clk);
            chk_word("indicator pins", {27'h0, rows[i].leds}, {27'h0, pin_level});
            chk_bit("speed", rows[i].spd, speed_indicator);
            chk_bit("line pairs", rows[i].spd, line_tx & line_rx);
        end
        $display("test indicator rows done");
        foreach (straps[i]) begin
            do_reset(straps[i]);
            chk_bit("isolate", straps[i] == 5'h00, mii_isolate);
            bus(1'b0, {24'h0, REG_CTRL_OFS}, 32'h0);
            chk_word("ctrl address", {27'h0, straps[i]}, rd & 32'h1F);
            chk_bit("ctrl isolate", straps[i] == 5'h00, rd[CTRL_ISOLATE_BIT]);
        end
        $display("test strap resets done");
        bus(1'b1, {24'h0, REG_CTRL_OFS}, 32'h00000300);
        bus(1'b0, {24'h0, REG_STATUS_OFS}, 32'h0);
        chk_bit("status isolate", 1'b0, rd[STAT_ISOLATE_BIT]);
        chk_bit("isolate pin", 1'b0, mii_isolate);
        frame(5'h00, 1'b1);
        frame(5'h1F, 1'b0);
        $display("test software address done");
        lk <= 7'h60;
        foreach (ctrl_words[i]) begin
            bus(1'b1, {24'h0, REG_CTRL_OFS}, ctrl_words[i]);
            repeat (3) @(posedge core_clk);
            chk_bit("forced speed", ctrl_words[i][9] & !ctrl_words[i][8], speed_indicator);
            chk_bit("forced lines", ctrl_words[i][9] & !ctrl_words[i][8], line_rx);
            chk_bit("forced duplex", ctrl_words[i][10] & !ctrl_words[i][8], pin_level[PIN_DUPLEX]);
            chk_bit("written isolate", ctrl_words[i][CTRL_ISOLATE_BIT], mii_isolate);
        end
        bus(1'b0, 32'h00000040, 32'h0);
        chk_word("unmapped read", 32'h0, rd);
        lk <= 7'h07;
        bus(1'b0, {24'h0, REG_ACTIVITY_OFS}, 32'h0);
        chk_word("activity word", 32'h00000007, rd);
        $display("test forced speed done");
        complete_run();
    end

    initial begin
        repeat (4000) @(posedge core_clk);
        fails++;
        complete_run();
    end
endmodule // plsc_top_tb_top
